// file: core/split_ctl_pkg.sv
/*
 Shared constants, command and pin types for the split-transfer host controller.
 Assumes a 125 MHz core clock and a multiport DRAM wired pin for pin to the pins_t fields.
*/
package split_ctl_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int PWR_WAIT_US = 200;
	localparam int PWR_WAIT_CYC = (PWR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHASE_NS = 60;
	localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STS_NS = 30;
	localparam int STS_CYC = (STS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STS_W = $clog2(STS_CYC + 1);
	localparam int PH_W = $clog2(PHASE_CYC + 1);
	localparam int INIT_CYCLES = 8;
	localparam int SC_HALF_CYC = 4;
	localparam int ADDR_W = 9;
	localparam int DQ_W = 16;
	localparam int STOP_LSB = 4;

	typedef enum logic [2:0] {
		OP_READ_XFER,
		OP_MASKED_WRITE_XFER,
		OP_SPLIT_READ,
		OP_SPLIT_WRITE,
		OP_STOP_SET,
		OP_REG_RESET,
		OP_REFRESH_RAS,
		OP_REFRESH_CBR
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic [3:0] stop_code;
		logic [DQ_W-1:0] mask;
		logic wr_low;
		logic wr_high;
	} cmd_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic trg_n;
		logic wel_n;
		logic weu_n;
		logic special_function_in;
		logic [ADDR_W-1:0] addr;
		logic [DQ_W-1:0] dq;
		logic dq_oe;
	} pins_t;

	localparam pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000, 16'h0000, 1'b0};

	// Stop code bits are ordered A4, A5, A6, A7 from msb to lsb.
	function automatic logic [4:0] stops_of(input logic [3:0] code);
		logic [4:0] n;
		n = 5'h10;
		casez (code)
			4'b1111: n = 5'h01;
			4'b1110: n = 5'h02;
			4'b110?: n = 5'h04;
			4'b10??: n = 5'h08;
			default: n = 5'h10;
		endcase
		return n;
	endfunction
endpackage

// file: core/sc_divider.sv
/*
 Serial shift clock generator: divides the core clock and flags each rising edge.
 Assumes run is a same-domain level; the clock always stops low, completing any high half under way.
*/
`timescale 1ns/1ns
module sc_divider
	import split_ctl_pkg::*;
#(
	parameter int HALF = SC_HALF_CYC
)
(
	// Clock and control
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	// Clock out
	output logic sc,
	output logic sc_rise
);
	localparam int CW = $clog2(HALF + 1);
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic sc_r, sc_nxt;
	logic rise_r, rise_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		sc_nxt = sc_r;
		rise_nxt = 1'b0;
		if (run || sc_r)
		begin
			if (cnt_r == CW'(HALF - 1))
			begin
				cnt_nxt = '0;
				sc_nxt = ~sc_r;
				rise_nxt = ~sc_r;
			end
			else
			begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
		else
		begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			sc_r <= 1'b0;
			rise_r <= 1'b0;
		end
		else if (ce)
		begin
			cnt_r <= cnt_nxt;
			sc_r <= sc_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign sc = sc_r;
	assign sc_rise = rise_r & ce;
endmodule

// file: core/split_xfer_host.sv
/*
 Host controller that drives a multiport DRAM's strobes and serial clock for split transfers,
 stop-set and register-reset cycles, and the power-up initialization.
 Assumes the device pins are wired to pins_t; half_indicator_out arrives asynchronously.
*/
`timescale 1ns/1ns
module split_xfer_host
	import split_ctl_pkg::*;
#(
	parameter int PWR_CYC = PWR_WAIT_CYC
)
(
	// Clock, reset and enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// User command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cmd_t cmd,
	output logic cmd_err,
	input wire logic use_refresh_counter,
	input wire logic shift_en,
	// Status
	output logic init_done,
	output logic busy,
	output logic active_half,
	output logic stop_mode,
	output logic [4:0] stop_points,
	output logic conv_read_done,
	output logic masked_write_done,
	// Device pins
	output pins_t pins,
	output logic serial_shift_clock,
	input wire logic half_indicator_out
);
	localparam int PWR_W = $clog2(PWR_CYC + 1);

	typedef enum logic [2:0] {ST_PWR, ST_SETUP, ST_RAS, ST_CAS, ST_END, ST_PRE, ST_DUMMY, ST_IDLE} state_t;

	state_t state_r, state_nxt;
	op_t op_r, op_nxt;
	cmd_t cmd_r, cmd_nxt;
	logic [PH_W-1:0] ph_r, ph_nxt;
	logic [PWR_W-1:0] pwr_r, pwr_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic init_r, init_nxt;
	logic err_r, err_nxt;
	logic crd_r, crd_nxt;
	logic mwt_r, mwt_nxt;
	logic stop_r, stop_nxt;
	logic [4:0] npts_r, npts_nxt;
	logic [STS_W-1:0] sts_r, sts_nxt;
	logic hs1_r, hs2_r, hprev_r;
	pins_t pins_r, pins_nxt;
	logic sc_rise;
	logic ph_done, is_split, is_xfer, is_cbr, wlo, whi, accept, half_edge;

	// The half indicator is unrelated to the core clock, so it is synchronised first.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			hs1_r <= 1'b0;
			hs2_r <= 1'b0;
			hprev_r <= 1'b0;
		end
		else if (ce)
		begin
			hs1_r <= half_indicator_out;
			hs2_r <= hs1_r;
			hprev_r <= hs2_r;
		end
	end
	assign half_edge = hs2_r ^ hprev_r;

	sc_divider #(.HALF(SC_HALF_CYC)) u_sc (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.run((state_r == ST_DUMMY) || (init_r && shift_en)),
		.sc(serial_shift_clock),
		.sc_rise(sc_rise)
	);

	assign ph_done = (ph_r == PH_W'(PHASE_CYC - 1));
	assign is_split = (cmd.op == OP_SPLIT_READ) || (cmd.op == OP_SPLIT_WRITE);
	assign cmd_ready = ce && (state_r == ST_IDLE) && !(is_split && (sts_r != '0));
	assign accept = cmd_valid && cmd_ready;

	always_comb
	begin
		state_nxt = state_r;
		op_nxt = op_r;
		cmd_nxt = cmd_r;
		ph_nxt = ph_r;
		pwr_nxt = pwr_r;
		cnt_nxt = cnt_r;
		init_nxt = init_r;
		err_nxt = 1'b0;
		crd_nxt = crd_r;
		mwt_nxt = mwt_r;
		stop_nxt = stop_r;
		npts_nxt = npts_r;
		sts_nxt = half_edge ? STS_W'(STS_CYC) : ((sts_r != '0) ? sts_r - 1'b1 : sts_r);
		case (state_r)
			ST_PWR:
			begin
				if (pwr_r == PWR_W'(PWR_CYC - 1))
				begin
					state_nxt = ST_SETUP;
					op_nxt = use_refresh_counter ? OP_REFRESH_CBR : OP_REFRESH_RAS;
					ph_nxt = '0;
				end
				else
				begin
					pwr_nxt = pwr_r + 1'b1;
				end
			end
			ST_SETUP, ST_RAS, ST_CAS, ST_END:
			begin
				ph_nxt = ph_done ? '0 : ph_r + 1'b1;
				if (ph_done)
				begin
					state_nxt = state_t'(state_r + 3'd1);
				end
				if (ph_done && (state_r == ST_SETUP))
				begin
					case (op_r)
						OP_READ_XFER:
						begin
							crd_nxt = 1'b1;
							mwt_nxt = 1'b0;
						end
						OP_MASKED_WRITE_XFER:
						begin
							mwt_nxt = 1'b1;
							crd_nxt = 1'b0;
						end
						OP_STOP_SET:
						begin
							stop_nxt = 1'b1;
							npts_nxt = stops_of(cmd_r.stop_code);
						end
						OP_REG_RESET:
						begin
							stop_nxt = 1'b0;
							npts_nxt = 5'h00;
						end
						default:
						begin
							stop_nxt = stop_r;
						end
					endcase
				end
			end
			ST_PRE:
			begin
				ph_nxt = ph_done ? '0 : ph_r + 1'b1;
				if (ph_done)
				begin
					if (init_r)
					begin
						state_nxt = ST_IDLE;
					end
					else if (op_r == OP_REG_RESET)
					begin
						init_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
					else if (cnt_r == 4'(INIT_CYCLES - 1))
					begin
						cnt_nxt = 4'h0;
						state_nxt = ST_DUMMY;
					end
					else
					begin
						cnt_nxt = cnt_r + 1'b1;
						state_nxt = ST_SETUP;
					end
				end
			end
			ST_DUMMY:
			begin
				if (cnt_r == 4'(INIT_CYCLES))
				begin
					state_nxt = ST_SETUP;
					op_nxt = OP_REG_RESET;
					ph_nxt = '0;
				end
				else if (sc_rise)
				begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			default:
			begin
				if (accept)
				begin
					if (((cmd.op == OP_SPLIT_READ) && !crd_r) || ((cmd.op == OP_SPLIT_WRITE) && !mwt_r))
					begin
						err_nxt = 1'b1;
					end
					else
					begin
						state_nxt = ST_SETUP;
						op_nxt = cmd.op;
						cmd_nxt = cmd;
						ph_nxt = '0;
					end
				end
			end
		endcase
	end

	// Pin levels follow the next state so they leave flip-flops in step with it.
	always_comb
	begin
		pins_nxt = PINS_IDLE;
		is_xfer = (op_nxt == OP_READ_XFER) || (op_nxt == OP_MASKED_WRITE_XFER) ||
			(op_nxt == OP_SPLIT_READ) || (op_nxt == OP_SPLIT_WRITE);
		is_cbr = (op_nxt == OP_STOP_SET) || (op_nxt == OP_REG_RESET) || (op_nxt == OP_REFRESH_CBR);
		wlo = cmd_nxt.wr_low | ~cmd_nxt.wr_high;
		whi = cmd_nxt.wr_high;
		if ((state_nxt == ST_SETUP) || (state_nxt == ST_RAS) || (state_nxt == ST_CAS) ||
			(state_nxt == ST_END))
		begin
			pins_nxt.ras_n = (state_nxt == ST_SETUP);
			pins_nxt.trg_n = !(is_xfer && (state_nxt != ST_END));
			pins_nxt.cas_n = !(is_cbr || (is_xfer && (state_nxt != ST_SETUP) &&
				(state_nxt != ST_RAS)));
			pins_nxt.special_function_in = (op_nxt == OP_SPLIT_READ) || (op_nxt == OP_SPLIT_WRITE) ||
				(op_nxt == OP_STOP_SET);
			if ((op_nxt == OP_MASKED_WRITE_XFER) || (op_nxt == OP_SPLIT_WRITE))
			begin
				pins_nxt.wel_n = !wlo;
				pins_nxt.weu_n = !whi;
			end
			else if (op_nxt == OP_STOP_SET)
			begin
				pins_nxt.wel_n = 1'b0;
			end
			if ((state_nxt == ST_SETUP) || (state_nxt == ST_RAS))
			begin
				pins_nxt.addr = cmd_nxt.row;
				if (op_nxt == OP_STOP_SET)
				begin
					pins_nxt.addr = '0;
					pins_nxt.addr[STOP_LSB+3:STOP_LSB] = {cmd_nxt.stop_code[0], cmd_nxt.stop_code[1],
						cmd_nxt.stop_code[2], cmd_nxt.stop_code[3]};
				end
				pins_nxt.dq = cmd_nxt.mask;
				pins_nxt.dq_oe = (op_nxt == OP_MASKED_WRITE_XFER) || (op_nxt == OP_SPLIT_WRITE);
			end
			else if (is_xfer)
			begin
				pins_nxt.addr = cmd_nxt.col;
				if ((op_nxt == OP_SPLIT_READ) || (op_nxt == OP_SPLIT_WRITE))
				begin
					pins_nxt.addr[ADDR_W-1] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_r <= ST_PWR;
			op_r <= OP_REFRESH_RAS;
			cmd_r <= '0;
			ph_r <= '0;
			pwr_r <= '0;
			cnt_r <= 4'h0;
			init_r <= 1'b0;
			err_r <= 1'b0;
			crd_r <= 1'b0;
			mwt_r <= 1'b0;
			stop_r <= 1'b0;
			npts_r <= 5'h00;
			sts_r <= '0;
			pins_r <= PINS_IDLE;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			cmd_r <= cmd_nxt;
			ph_r <= ph_nxt;
			pwr_r <= pwr_nxt;
			cnt_r <= cnt_nxt;
			init_r <= init_nxt;
			err_r <= err_nxt;
			crd_r <= crd_nxt;
			mwt_r <= mwt_nxt;
			stop_r <= stop_nxt;
			npts_r <= npts_nxt;
			sts_r <= sts_nxt;
			pins_r <= pins_nxt;
		end
	end

	assign pins = pins_r;
	assign cmd_err = err_r;
	assign init_done = init_r;
	assign busy = (state_r != ST_IDLE);
	assign active_half = hprev_r;
	assign stop_mode = stop_r;
	assign stop_points = npts_r;
	assign conv_read_done = crd_r;
	assign masked_write_done = mwt_r;

	AST_PWR_HIGH: assert property (@(posedge core_clk) disable iff (rst)
		(state_r == ST_PWR) |-> (pins_r.ras_n && pins_r.trg_n))
		else $error("strobes not high during power-up pause");
	AST_INIT_TRG: assert property (@(posedge core_clk) disable iff (rst)
		!init_r |-> pins_r.trg_n)
		else $error("transfer strobe low during initialization");
	AST_DUMMY_COUNT: assert property (@(posedge core_clk) disable iff (rst)
		((state_r == ST_DUMMY) && (state_nxt != ST_DUMMY) && ce) |-> (cnt_r == 4'd8))
		else $error("left dummy serial cycles early");
	AST_SPLIT_DELAY: assert property (@(posedge core_clk) disable iff (rst)
		(half_edge && ce) |=> (sts_r == STS_W'(STS_CYC)) ##0 (cmd_ready == 1'b0 || !is_split))
		else $error("split delay not armed after half change");
	AST_SPLIT_RD_PRE: assert property (@(posedge core_clk) disable iff (rst)
		($fell(pins_r.ras_n) && !pins_r.trg_n && pins_r.special_function_in && pins_r.cas_n && pins_r.wel_n &&
		pins_r.weu_n) |-> crd_r)
		else $error("split read without preceding read transfer");
	AST_SPLIT_WR_PRE: assert property (@(posedge core_clk) disable iff (rst)
		($fell(pins_r.ras_n) && !pins_r.trg_n && pins_r.special_function_in && pins_r.cas_n &&
		!(pins_r.wel_n && pins_r.weu_n)) |-> mwt_r)
		else $error("split write without preceding masked write transfer");
	AST_STOP_ADDR: assert property (@(posedge core_clk) disable iff (rst)
		($fell(pins_r.ras_n) && !pins_r.cas_n && pins_r.special_function_in) |->
		(!pins_r.wel_n && (pins_r.addr[3:0] == 4'h0) && stop_r &&
		(npts_r == stops_of({pins_r.addr[4], pins_r.addr[5], pins_r.addr[6], pins_r.addr[7]}))))
		else $error("stop-set cycle malformed");
	AST_REG_RESET: assert property (@(posedge core_clk) disable iff (rst)
		($fell(pins_r.ras_n) && !pins_r.cas_n && !pins_r.special_function_in && (op_r == OP_REG_RESET)) |->
		(pins_r.wel_n && pins_r.weu_n && !stop_r && (npts_r == 5'h00)))
		else $error("register reset did not clear stop mode");
	AST_XFER_STROBE: assert property (@(posedge core_clk) disable iff (rst)
		($fell(pins_r.ras_n) && pins_r.cas_n && (op_r != OP_REFRESH_RAS)) |-> !pins_r.trg_n)
		else $error("transfer requested without transfer strobe low");

	COV_INIT: cover property (@(posedge core_clk) disable iff (rst) $rose(init_r));
	COV_SPLIT_RD: cover property (@(posedge core_clk) disable iff (rst)
		(state_r == ST_RAS) && (op_r == OP_SPLIT_READ));
	COV_SPLIT_WR: cover property (@(posedge core_clk) disable iff (rst)
		(state_r == ST_RAS) && (op_r == OP_SPLIT_WRITE));
	COV_STOP_SET: cover property (@(posedge core_clk) disable iff (rst) $rose(stop_r));
endmodule

// file: dv/split_dev_model.sv
/*
 Behavioural model of the multiport DRAM's split-transfer side, decoding cycles at row strobe fall.
 Assumes the host drives every pin and the serial shift clock; the model drives only the half flag.
*/
`timescale 1ns/1ns
module split_dev_model
	import split_ctl_pkg::*;
#(
	parameter int HALF = 256
)
(
	// Device pins
	input wire pins_t pins,
	input wire logic sc,
	output logic half_ind,
	// Observation
	output op_t kind,
	output logic [4:0] stops,
	output logic [15:0] n_ras,
	output logic [15:0] n_cbr,
	output logic [15:0] n_sc,
	output logic [8:0] col_seen,
	output logic [15:0] dq_seen,
	output logic bad
);
	int shifts = 0;
	time t_tog = 0;
	logic rd_done = 1'b0;
	logic mw_done = 1'b0;
	initial
	begin
		{half_ind, stops, n_ras, n_cbr, n_sc, col_seen, dq_seen, bad} = '0;
		kind = OP_REFRESH_RAS;
	end
	// Strobes are taken whenever they fall, with no tie to the shift clock.
	always @(negedge pins.ras_n)
	begin
		n_ras++;
		dq_seen = pins.dq_oe ? pins.dq : 16'h0000;
		if (!pins.trg_n && pins.special_function_in)
		begin
			kind = (pins.wel_n & pins.weu_n) ? OP_SPLIT_READ : OP_SPLIT_WRITE;
			if ($time - t_tog < STS_NS)
				bad = 1'b1;
			if (kind == OP_SPLIT_READ ? !rd_done : !mw_done)
				bad = 1'b1;
		end
		else if (!pins.trg_n)
		begin
			kind = (pins.wel_n & pins.weu_n) ? OP_READ_XFER : OP_MASKED_WRITE_XFER;
			rd_done = (kind == OP_READ_XFER);
			mw_done = !rd_done;
		end
		else if (!pins.cas_n && pins.special_function_in && !(pins.wel_n & pins.weu_n))
		begin
			kind = OP_STOP_SET;
			casez ({pins.addr[4], pins.addr[5], pins.addr[6], pins.addr[7]})
				4'b1111: stops = 5'h01;
				4'b1110: stops = 5'h02;
				4'b110?: stops = 5'h04;
				4'b10??: stops = 5'h08;
				default: stops = 5'h10;
			endcase
		end
		else if (!pins.cas_n && !pins.special_function_in && pins.wel_n && pins.weu_n)
		begin
			kind = OP_REG_RESET;
			stops = 5'h00;
			n_cbr++;
		end
		else
			kind = OP_REFRESH_RAS;
	end
	always @(negedge pins.cas_n)
		col_seen = pins.addr;
	// One half shifts while the other is reloaded; a stop point switches halves.
	always @(posedge sc)
	begin
		n_sc++;
		shifts++;
		if (shifts >= ((stops != 5'h00) ? HALF / stops : HALF))
		begin
			shifts = 0;
			half_ind = ~half_ind;
			t_tog = $time;
		end
	end
endmodule

// file: dv/split_xfer_host_bench.sv
/*
 Self-checking bench for the split-transfer host controller against the device model.
 Assumes a 125 MHz core clock and a shortened power-up pause of 20 cycles.
*/
`timescale 1ns/1ns
module split_xfer_host_bench;
	import split_ctl_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic cmd_valid = 1'b0;
	cmd_t cmd = '0;
	logic use_refresh_counter = 1'b0;
	logic shift_en = 1'b0;
	logic cmd_ready, cmd_err, init_done, busy, active_half, stop_mode;
	logic conv_read_done, masked_write_done, sck, half, bad;
	logic [4:0] stop_points, stops;
	pins_t pins;
	op_t kind;
	logic [15:0] n_ras, n_cbr, n_sc, dq_seen;
	logic [8:0] col_seen;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	split_xfer_host #(.PWR_CYC(20)) u_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_err(cmd_err),
		.use_refresh_counter(use_refresh_counter), .shift_en(shift_en), .init_done(init_done),
		.busy(busy), .active_half(active_half), .stop_mode(stop_mode),
		.stop_points(stop_points), .conv_read_done(conv_read_done),
		.masked_write_done(masked_write_done), .pins(pins), .serial_shift_clock(sck),
		.half_indicator_out(half));
	split_dev_model u_dev (.pins(pins), .sc(sck), .half_ind(half), .kind(kind),
		.stops(stops), .n_ras(n_ras), .n_cbr(n_cbr), .n_sc(n_sc), .col_seen(col_seen),
		.dq_seen(dq_seen), .bad(bad));
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic do_cmd(input op_t op, input logic [3:0] code, input logic e);
		int n;
		n = 0;
		@(negedge core_clk);
		cmd = '{op, 9'h1a5, 9'h1ff, code, 16'h5a3c, 1'b1, 1'b0};
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 400)
		begin
			@(negedge core_clk);
			n++;
		end
		@(negedge core_clk);
		cmd_valid = 1'b0;
		check(cmd_err, e);
		n = 0;
		while (busy !== 1'b0 && n < 60)
		begin
			@(negedge core_clk);
			n++;
		end
		check(busy, 1'b0);
	endtask
	task automatic t_init(input logic refcnt);
		logic [15:0] r0, c0, s0;
		int n;
		{r0, c0, s0} = {n_ras, n_cbr, n_sc};
		n = 0;
		@(negedge core_clk);
		rst = 1'b1;
		use_refresh_counter = refcnt;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		repeat (19) @(negedge core_clk);
		check(n_ras - r0, 16'h0000);
		while (init_done !== 1'b1 && n < 2000)
		begin
			@(negedge core_clk);
			n++;
		end
		check(n_ras - r0, 16'h0009);
		check(n_cbr - c0, refcnt ? 16'h0009 : 16'h0001);
		check(16'(n_sc - s0 >= 16'h0008), 16'h0001);
		check(16'(kind), 16'(OP_REG_RESET));
		check(16'(init_done), 16'h0001);
	endtask
	task automatic t_order();
		logic [15:0] r0;
		r0 = n_ras;
		do_cmd(OP_SPLIT_READ, 4'h0, 1'b1);
		do_cmd(OP_SPLIT_WRITE, 4'h0, 1'b1);
		check(n_ras - r0, 16'h0000);
	endtask
	task automatic t_xfer();
		op_t ops [4] = '{OP_READ_XFER, OP_SPLIT_READ, OP_MASKED_WRITE_XFER, OP_SPLIT_WRITE};
		foreach (ops[i])
		begin
			do_cmd(ops[i], 4'h0, 1'b0);
			check(16'(kind), 16'(ops[i]));
		end
		check(16'(col_seen[8]), 16'h0000);
		check(dq_seen, 16'h5a3c);
		check(16'(masked_write_done), 16'h0001);
		check(16'(conv_read_done), 16'h0000);
	endtask
	task automatic t_stops();
		logic [3:0] codes [5] = '{4'hf, 4'he, 4'hd, 4'hb, 4'h7};
		logic [4:0] exp [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
		foreach (codes[i])
		begin
			do_cmd(OP_STOP_SET, codes[i], 1'b0);
			check(16'(stops), 16'(exp[i]));
			check(16'(stop_points), 16'(exp[i]));
		end
		do_cmd(OP_SPLIT_WRITE, 4'h0, 1'b0);
		check(16'(stop_mode), 16'h0001);
		do_cmd(OP_REG_RESET, 4'h0, 1'b0);
		check(16'({stop_mode, stops, stop_points}), 16'h0000);
	endtask
	task automatic t_delay();
		logic h;
		int n;
		n = 0;
		do_cmd(OP_READ_XFER, 4'h0, 1'b0);
		check(16'(conv_read_done), 16'h0001);
		shift_en = 1'b1;
		cmd.op = OP_SPLIT_READ;
		h = active_half;
		while (active_half === h && n < 3000)
		begin
			@(negedge core_clk);
			n++;
		end
		check(16'(active_half), 16'(!h));
		check(16'(cmd_ready), 16'h0000);
		n = 0;
		while (cmd_ready !== 1'b1 && n < 20)
		begin
			@(negedge core_clk);
			n++;
		end
		check(16'(n), 16'(STS_CYC));
		do_cmd(OP_SPLIT_READ, 4'h0, 1'b0);
		ce = 1'b0;
		@(negedge core_clk);
		check(16'(cmd_ready), 16'h0000);
		ce = 1'b1;
		shift_en = 1'b0;
	endtask
	initial
	begin
		t_init(1'b0);
		t_order();
		t_xfer();
		t_stops();
		t_delay();
		t_init(1'b1);
		check(16'(bad), 16'h0000);
		give_verdict();
	end
endmodule
